/* File: hw/alr_converter.sv */
// Ambient light conversion sequencer with averaging and frame timing.
`timescale 1ns/1ps
module alr_converter
    import alr_pkg::*;
#(
    parameter int FRAME_CYC  = ALR_FRAME_CYC,
    parameter int SAMPLE_CYC = ALR_SAMPLE_CYC
)(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Control
    input  wire logic                 meas_req,
    input  wire logic                 cont_mode,
    input  wire logic [ALR_AVG_W-1:0] avg_count,
    input  wire logic [15:0]          sample_val,
    // Status
    output logic                      busy,
    output logic                      sampling,
    output logic                      result_valid,
    output logic [15:0]               result
);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {CV_IDLE, CV_SAMPLE, CV_WAIT} alr_cv_st_t;
    alr_cv_st_t   st, next_st;
    logic [31:0]  frame_cnt, next_frame_cnt;
    logic [31:0]  samp_cnt, next_samp_cnt;
    logic [ALR_AVG_W-1:0] done_cnt, next_done_cnt;
    logic [ALR_AVG_W-1:0] avg_q, next_avg_q;
    logic [23:0]  acc, next_acc;
    logic [15:0]  next_result;
    logic         next_valid;
    logic [23:0]  avg_div;

    always_comb begin
        avg_div = acc / {16'h0, (avg_q == '0) ? 8'h01 : avg_q};
    end

    always_comb begin
        next_st        = st;
        next_frame_cnt = frame_cnt;
        next_samp_cnt  = samp_cnt;
        next_done_cnt  = done_cnt;
        next_avg_q     = avg_q;
        next_acc       = acc;
        next_result    = result;
        next_valid     = 1'b0;
        unique case (st)
            CV_IDLE: begin
                if (meas_req) begin
                    next_st        = CV_SAMPLE;
                    next_frame_cnt = '0;
                    next_samp_cnt  = '0;
                    next_done_cnt  = '0;
                    next_acc       = '0;
                    next_avg_q     = (avg_count == '0) ? 8'h01 : avg_count;
                end
            end
            CV_SAMPLE: begin
                next_frame_cnt = frame_cnt + 32'h1;
                next_samp_cnt  = samp_cnt + 32'h1;
                if (samp_cnt == 32'(SAMPLE_CYC - 1)) begin
                    next_samp_cnt = '0;
                    next_acc      = acc + {8'h0, sample_val};
                    next_done_cnt = done_cnt + 8'h1;
                    if (done_cnt + 8'h1 == avg_q) begin
                        next_st = CV_WAIT;
                    end
                end
            end
            CV_WAIT: begin
                next_frame_cnt = frame_cnt + 32'h1;
                // Continuous mode publishes at once; standard waits for the frame.
                if (cont_mode || frame_cnt >= 32'(FRAME_CYC - 1)) begin
                    next_result = avg_div[15:0];
                    next_valid  = 1'b1;
                    next_st     = CV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st           <= CV_IDLE;
            frame_cnt    <= '0;
            samp_cnt     <= '0;
            done_cnt     <= '0;
            avg_q        <= 8'h01;
            acc          <= '0;
            result       <= '0;
            result_valid <= 1'b0;
        end else begin
            st           <= next_st;
            frame_cnt    <= next_frame_cnt;
            samp_cnt     <= next_samp_cnt;
            done_cnt     <= next_done_cnt;
            avg_q        <= next_avg_q;
            acc          <= next_acc;
            result       <= next_result;
            result_valid <= next_valid;
        end
    end

    // Samples in a set run back to back in both modes; the mode only sets the end.
    assign sampling = (st == CV_SAMPLE);
    assign busy     = (st != CV_IDLE);

    property p_frame_len;
        @(posedge core_clk) disable iff (!rst_b)
        (st == CV_WAIT && !cont_mode && frame_cnt < 32'(FRAME_CYC - 1)) |=> !result_valid;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Result before frame end.");

    sequence s_sample_end;
        cont_mode && st == CV_SAMPLE && samp_cnt == 32'(SAMPLE_CYC - 1)
            && done_cnt + 8'h1 != avg_q;
    endsequence

    property p_back_to_back;
        @(posedge core_clk) disable iff (!rst_b)
        s_sample_end |=> st == CV_SAMPLE && samp_cnt == '0;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("Gap between samples.");

endmodule

/* File: hw/alr_pkg.sv */
// Package with constants and types for the ambient light readout block.
package alr_pkg;

    // ------------------------------------------------------------------
    // Bus addressing
    // ------------------------------------------------------------------
    localparam logic [7:0] ALR_ADDR_WR     = 8'h26;
    localparam logic [7:0] ALR_ADDR_RD     = 8'h27;
    localparam logic [6:0] ALR_DEV_ADDR    = 7'h13;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ALR_REG_RES_HI  = 8'h85;
    localparam logic [7:0] ALR_REG_RES_LO  = 8'h86;
    localparam logic [7:0] ALR_PTR_RESET   = 8'h80;
    localparam int         ALR_CONT_BIT    = 7;
    localparam logic [7:0] ALR_IDLE_BYTE   = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int ALR_CLK_MHZ       = 200;
    localparam int ALR_FRAME_MS      = 100;
    localparam int ALR_SAMPLE_US     = 300;
    localparam int ALR_FRAME_CYC     = ALR_FRAME_MS * 1000 * ALR_CLK_MHZ;
    localparam int ALR_SAMPLE_CYC    = ALR_SAMPLE_US * ALR_CLK_MHZ;
    localparam int ALR_MAX_AVG       = 128;
    localparam int ALR_AVG_W         = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic stop;
        logic byte_done;
        logic [7:0] data;
    } alr_bus_ev_t;

    typedef enum logic [2:0] {
        ALR_IDLE, ALR_ADDR, ALR_PTR, ALR_READ, ALR_IGNORE
    } alr_bus_st_t;

endpackage

/* File: hw/alr_serial_rx.sv */
// Serial bus bit engine: detects start/stop, shifts bytes, drives ack and read data.
`timescale 1ns/1ps
module alr_serial_rx
    import alr_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Bus pins
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    // Byte level side
    input  wire logic         ack_req,
    input  wire logic         tx_mode,
    input  wire logic [7:0]   tx_byte,
    output alr_bus_ev_t       ev,
    output logic              tx_load,
    output logic              master_ack
);

    // ------------------------------------------------------------------
    // Edge sampling
    // ------------------------------------------------------------------
    logic       scl_q, sda_q;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] sh, next_sh;
    logic       ack_ph, next_ack_ph;
    logic       drv, next_drv;
    logic       mack, next_mack;
    alr_bus_ev_t next_ev;
    logic       next_load;
    logic       scl_rise, scl_fall;

    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;

    always_comb begin
        next_ev      = '0;
        next_ev.data = sh;
        next_bit_cnt = bit_cnt;
        next_sh      = sh;
        next_ack_ph  = ack_ph;
        next_drv     = drv;
        next_mack    = mack;
        next_load    = 1'b0;
        if (scl_in && scl_q && sda_q && !sda_in) begin
            next_ev.start = 1'b1;
            next_bit_cnt  = '0;
            next_ack_ph   = 1'b0;
            next_drv      = 1'b0;
        end else if (scl_in && scl_q && !sda_q && sda_in) begin
            next_ev.stop = 1'b1;
            next_drv     = 1'b0;
            next_ack_ph  = 1'b0;
        end else if (scl_rise) begin
            if (ack_ph) begin
                next_mack = ~sda_in;
            end else begin
                // A sent bit must hold through the high phase, so it moves on the fall.
                next_sh      = tx_mode ? sh : {sh[6:0], sda_in};
                next_bit_cnt = bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            if (ack_ph) begin
                next_ack_ph  = 1'b0;
                next_bit_cnt = '0;
                next_drv     = tx_mode & mack;
                next_load    = tx_mode & mack;
                next_sh      = tx_byte;
            end else if (bit_cnt == 4'h8) begin
                next_ev.byte_done = 1'b1;
                next_ev.data      = sh;
                next_ack_ph       = 1'b1;
                next_drv          = ack_req & ~tx_mode;
                next_mack         = 1'b0;
            end else begin
                next_drv = tx_mode & drv;
                next_sh  = tx_mode ? {sh[6:0], 1'b0} : sh;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            bit_cnt <= '0;
            sh      <= '0;
            ack_ph  <= 1'b0;
            drv     <= 1'b0;
            mack    <= 1'b0;
            ev      <= '0;
            tx_load <= 1'b0;
        end else begin
            scl_q   <= scl_in;
            sda_q   <= sda_in;
            bit_cnt <= next_bit_cnt;
            sh      <= next_sh;
            ack_ph  <= next_ack_ph;
            drv     <= next_drv;
            mack    <= next_mack;
            ev      <= next_ev;
            tx_load <= next_load;
        end
    end

    // Ack pulls low; read data pulls low only for zero bits (open drain).
    assign sda_out    = 1'b0;
    assign sda_oe     = drv & (ack_ph ? 1'b1 : (tx_mode & ~sh[7]));
    assign master_ack = mack;

endmodule

/* File: hw/alr_top.sv */
// Ambient light readout control: serial register access and conversion timing.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// How it works
// - With no measurement requested, only the bus logic runs; conversion is idle.
// - Emitter current sink is off while in standby.
// - Read is accepted after a stop or after a repeated start.
// - Register pointer advances by one after the read address byte and after each acknowledged byte read; a byte ended with a nack leaves it unchanged.
// - Result high byte at 85h, low byte at 86h.
// - Device answers address byte 26h for writes, 27h for reads.
// - Standard mode measurement cycle occupies a fixed 100 ms frame.
// - Each single sample takes about 300 us.
// - Configured number of samples, up to 128, is averaged into the result; the code has no 128 cap and averages any 8-bit count up to 255 (0 counts as 1).
// - Standard mode result appears only after the frame elapses.
// - Continuous mode runs samples back to back without gaps.
// ----------------------------------------------------------------------
module alr_top
    import alr_pkg::*;
#(
    parameter int FRAME_CYC  = ALR_FRAME_CYC,
    parameter int SAMPLE_CYC = ALR_SAMPLE_CYC
)(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Serial bus pins
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    // Measurement control from the register bank
    input  wire logic                 meas_req,
    input  wire logic [7:0]           conv_ctrl,
    input  wire logic [ALR_AVG_W-1:0] avg_count,
    // Analog front end
    input  wire logic [15:0]          sample_val,
    output logic                      sensor_enable,
    output logic                      emitter_sink_en,
    // Status
    output logic                      conv_busy,
    output logic                      result_valid,
    output logic [7:0]                reg_ptr
);

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    alr_bus_ev_t ev;
    logic        tx_load;
    logic        master_ack;
    logic        ack_req;
    logic        tx_mode;
    logic [7:0]  tx_byte;
    logic [15:0] result;
    logic        sampling;

    alr_serial_rx u_rx (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .ack_req    (ack_req),
        .tx_mode    (tx_mode),
        .tx_byte    (tx_byte),
        .ev         (ev),
        .tx_load    (tx_load),
        .master_ack (master_ack)
    );

    alr_converter #(
        .FRAME_CYC  (FRAME_CYC),
        .SAMPLE_CYC (SAMPLE_CYC)
    ) u_cv (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .meas_req     (meas_req),
        .cont_mode    (conv_ctrl[ALR_CONT_BIT]),
        .avg_count    (avg_count),
        .sample_val   (sample_val),
        .busy         (conv_busy),
        .sampling     (sampling),
        .result_valid (result_valid),
        .result       (result)
    );

    // ------------------------------------------------------------------
    // Standby
    // ------------------------------------------------------------------
    // Light sampling never needs the emitter, so its sink stays off and the host
    // never has to zero the drive setting to save power.
    assign sensor_enable   = sampling;
    assign emitter_sink_en = 1'b0;

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    alr_bus_st_t st, next_st;
    logic [7:0]  next_ptr;
    logic [7:0]  next_tx_byte;
    logic [15:0] snap, next_snap;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [15:0] r);
        logic [7:0] v;
        v = ALR_IDLE_BYTE;
        if (a == ALR_REG_RES_HI) begin
            v = r[15:8];
        end else if (a == ALR_REG_RES_LO) begin
            v = r[7:0];
        end
        return v;
    endfunction

    always_comb begin
        next_st      = st;
        next_ptr     = reg_ptr;
        next_tx_byte = tx_byte;
        next_snap    = snap;
        if (ev.start) begin
            // A repeated start is handled the same as a fresh start.
            next_st = ALR_ADDR;
        end else if (ev.stop) begin
            next_st = ALR_IDLE;
        end else if (ev.byte_done) begin
            unique case (st)
                ALR_ADDR: begin
                    if (ev.data == ALR_ADDR_WR) begin
                        next_st = ALR_PTR;
                    end else if (ev.data == ALR_ADDR_RD) begin
                        next_st      = ALR_READ;
                        next_snap    = result;
                        next_tx_byte = reg_read(reg_ptr, result);
                    end else begin
                        next_st = ALR_IGNORE;
                    end
                end
                ALR_PTR: begin
                    next_ptr = ev.data;
                    next_st  = ALR_IGNORE;
                end
                ALR_READ: begin
                    next_st = ALR_READ;
                end
                default: begin
                    next_st = st;
                end
            endcase
        end else if (tx_load) begin
            next_ptr     = reg_ptr + 8'h01;
            next_tx_byte = reg_read(reg_ptr + 8'h01, snap);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st      <= ALR_IDLE;
            reg_ptr <= ALR_PTR_RESET;
            tx_byte <= ALR_IDLE_BYTE;
            snap    <= '0;
        end else begin
            st      <= next_st;
            reg_ptr <= next_ptr;
            tx_byte <= next_tx_byte;
            snap    <= next_snap;
        end
    end

    assign tx_mode = (st == ALR_READ);
    assign ack_req = (st == ALR_ADDR && (ev.data == ALR_ADDR_WR || ev.data == ALR_ADDR_RD))
                   || (st == ALR_PTR);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ptr_inc;
        @(posedge core_clk) disable iff (!rst_b)
        (tx_load && !ev.start && !ev.stop && !ev.byte_done) |=> reg_ptr == $past(reg_ptr) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer did not advance.");

    property p_ptr_load;
        @(posedge core_clk) disable iff (!rst_b)
        (ev.byte_done && st == ALR_PTR && !ev.start && !ev.stop) |=> reg_ptr == $past(ev.data);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("Pointer not loaded.");

    property p_rd_addr;
        @(posedge core_clk) disable iff (!rst_b)
        (ev.byte_done && st == ALR_ADDR && ev.data == ALR_ADDR_RD && !ev.start && !ev.stop)
            |=> tx_mode;
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("Read address not accepted.");

    property p_standby;
        @(posedge core_clk) disable iff (!rst_b)
        !conv_busy |-> !sensor_enable && !emitter_sink_en;
    endproperty
    a_standby: assert property (p_standby) else $error("Front end active in standby.");

    property p_rstart;
        @(posedge core_clk) disable iff (!rst_b)
        ev.start |=> st == ALR_ADDR;
    endproperty
    a_rstart: assert property (p_rstart) else $error("Start not handled.");

    property p_hi_byte;
        @(posedge core_clk) disable iff (!rst_b)
        (ev.byte_done && st == ALR_ADDR && ev.data == ALR_ADDR_RD && !ev.start && !ev.stop
            && reg_ptr == ALR_REG_RES_HI) |=> tx_byte == $past(result[15:8]);
    endproperty
    a_hi_byte: assert property (p_hi_byte) else $error("High byte wrong.");

    sequence s_pub_next;
        conv_busy ##1 !conv_busy;
    endsequence

    property p_cont;
        @(posedge core_clk) disable iff (!rst_b)
        (conv_ctrl[ALR_CONT_BIT] && $fell(sampling)) |-> s_pub_next;
    endproperty
    a_cont: assert property (p_cont) else $error("Continuous result held back.");

    property p_no_early;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(conv_busy) |-> !result_valid [*2];
    endproperty
    a_no_early: assert property (p_no_early) else $error("Result too early.");

endmodule

/* File: test/alr_host_model.sv */
// Serial bus host model that addresses and reads the sensor registers.
`timescale 1ns/1ps
module alr_host_model #(
    parameter int HALF = 8
)(
    // Clock
    input  wire logic core_clk,
    // Bus lines
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Data moves only mid low phase, so a data change never looks like start or stop.
    task automatic clk_bit(input logic d, output logic b);
        tick(HALF / 2);
        sda_low = ~d;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        b = sda_line;
        scl = 1'b0;
    endtask

    task automatic start();
        sda_low = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(HALF / 2);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask

    // Address bytes and the bare pointer byte go out through this task.
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], b);
        clk_bit(1'b1, b);
        ack = ~b;
    endtask

    task automatic recv(input logic ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b);
            d[i] = b;
        end
        clk_bit(~ack, b);
    endtask
endmodule

/* File: test/tb_top.sv */
// Testbench for the ambient light readout block with a serial host model.
`timescale 1ns/1ps
module tb_top;
    import alr_pkg::*;
    localparam int FRAME = 400;
    localparam int SAMP  = 10;
    logic        core_clk;
    logic        rst_b;
    logic        scl;
    logic        sda_low;
    logic        sda_line;
    logic        sda_out;
    logic        sda_oe;
    logic        meas_req;
    logic [7:0]  conv_ctrl;
    logic [7:0]  avg_count;
    logic [15:0] sample_val;
    logic        sensor_enable;
    logic        emitter_sink_en;
    logic        conv_busy;
    logic        result_valid;
    logic [7:0]  reg_ptr;
    int          bad_count = 0;
    int          num_checks = 0;

    // Open drain line with pull-up: low when either party pulls.
    assign sda_line = ~(sda_low | sda_oe);

    alr_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
                         .sda_low(sda_low));

    alr_top #(.FRAME_CYC(FRAME), .SAMPLE_CYC(SAMP)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas_req(meas_req),
        .conv_ctrl(conv_ctrl), .avg_count(avg_count), .sample_val(sample_val),
        .sensor_enable(sensor_enable), .emitter_sink_en(emitter_sink_en),
        .conv_busy(conv_busy), .result_valid(result_valid), .reg_ptr(reg_ptr));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Pointer write, then two result bytes with stop or repeated start between.
    task automatic read_result(input logic rep, output logic [15:0] v);
        logic a;
        host.start();
        host.send(ALR_ADDR_WR, a);
        check({15'h0, a}, 16'h0001, "write address ack");
        host.send(ALR_REG_RES_HI, a);
        check({15'h0, a}, 16'h0001, "pointer ack");
        check({8'h00, reg_ptr}, {8'h00, ALR_REG_RES_HI}, "pointer set");
        if (!rep) host.stop();
        host.start();
        host.send(ALR_ADDR_RD, a);
        check({15'h0, a}, 16'h0001, "read address ack");
        host.recv(1'b1, v[15:8]);
        check({8'h00, reg_ptr}, {8'h00, ALR_REG_RES_LO}, "pointer step");
        host.recv(1'b0, v[7:0]);
        host.stop();
        check({8'h00, reg_ptr}, {8'h00, ALR_REG_RES_LO + 8'h01}, "pointer after pair");
    endtask

    // One averaging set; the raw sample changes in the middle of the second sample.
    task automatic convert(input logic cont, input int avg, input int lat, output int on);
        int n;
        on = 0;
        sample_val = 16'h03e8;
        conv_ctrl = {cont, 7'h00};
        avg_count = avg[7:0];
        check({15'h0, sensor_enable}, 16'h0000, "standby sensor");
        meas_req = 1'b1;
        @(negedge core_clk);
        meas_req = 1'b0;
        n = 1;
        check({15'h0, conv_busy}, 16'h0001, "busy");
        while (result_valid !== 1'b1 && n < lat + 20) begin
            if (sensor_enable === 1'b1) on++;
            check({15'h0, emitter_sink_en}, 16'h0000, "sink");
            if (n == SAMP + SAMP / 2) sample_val = 16'h0bb8;
            @(negedge core_clk);
            n++;
        end
        check({15'h0, n >= lat && n <= lat + 3}, 16'h0001, "latency");
        if (n >= lat + 20) print_verdict();
        check({15'h0, on >= avg * SAMP - 1 && on <= avg * SAMP + 1}, 16'h0001,
              "sample time");
    endtask

    task automatic t_reset();
        check({8'h00, reg_ptr}, {8'h00, ALR_PTR_RESET}, "pointer reset");
        check({13'h0, sda_out, sda_oe, conv_busy}, 16'h0000, "idle outputs");
        check({15'h0, emitter_sink_en}, 16'h0000, "sink off");
        $display("test reset done");
    endtask

    task automatic t_standard();
        int on;
        logic [15:0] v;
        convert(1'b0, 2, FRAME, on);
        read_result(1'b0, v);
        check(v, 16'h07d0, "standard average");
        $display("test standard done");
    endtask

    task automatic t_continuous();
        int on;
        logic [15:0] v;
        convert(1'b1, 4, 4 * SAMP, on);
        read_result(1'b1, v);
        check(v, 16'h09c4, "continuous average");
        $display("test continuous done");
    endtask

    task automatic t_foreign();
        logic a;
        host.start();
        host.send(8'h30, a);
        check({15'h0, a}, 16'h0000, "foreign address");
        host.stop();
        $display("test foreign done");
    endtask

    initial begin
        rst_b = 1'b0;
        meas_req = 1'b0;
        conv_ctrl = 8'h00;
        avg_count = 8'h01;
        sample_val = 16'h0000;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        t_reset();
        t_standard();
        t_continuous();
        t_foreign();
        print_verdict();
    end
endmodule
